//--- ahpbh_pkg.sv
// constants and types of the asynchronous host port and bus handoff block
// assumes a core clock of 100 MHz and an external bus clock derived from it
package ahpbh_pkg;

  // ****************************************
  // clocking
  // ****************************************
  localparam int CORE_PERIOD_PS = 10000;
  localparam int CLK_RATIO = 4;
  // host read: ready held low at least 1.5 core periods
  localparam int RD_LOW_MIN_PS = 15000;
  localparam int RD_LOW_CYC = (RD_LOW_MIN_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  // bus synchronization after reset release
  localparam int SYNC_CYC = 16;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int ADDR_W = 18;
  localparam int IOP_W = 9;
  localparam int DATA_W = 32;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [5:0] {
    BUS_SYNC = 6'b00_0001,
    BUS_OWN = 6'b00_0010,
    BUS_GIVE = 6'b00_0100,
    BUS_HOST = 6'b00_1000,
    BUS_TAKE = 6'b01_0000,
    BUS_SUSP = 6'b10_0000
  } ahpbh_bus_t;

  typedef enum logic [3:0] {
    ACC_IDLE = 4'b0001,
    ACC_RD = 4'b0010,
    ACC_WR = 4'b0100,
    ACC_DONE = 4'b1000
  } ahpbh_acc_t;

endpackage : ahpbh_pkg

//--- ahpbh_top.sv
// host access port with handoff of the external memory interface
// assumes all pins are synchronous to I_CLK; the host keeps its side of the handshake
//
// Summary of operation
// - request seen before reset; grant after sync
// - host reaches only I/O processor registers
// - reset ignores suspend, requests and multiprocessor accesses
// - write stalls on ready only when FIFO full
// - read: ready low 2 cycles, data first
// - float address, strobes, boot select before grant
// - resume driving one external period after grant
// - floated set: address, strobes, selects, boot select
// - grant and clock enable offset by one and a half ratios
// - sequencing on bus, host transitions and suspend
module ahpbh_top #(
  parameter int CLK_RATIO = ahpbh_pkg::CLK_RATIO,
  parameter int ADDR_W = ahpbh_pkg::ADDR_W,
  parameter int IOP_W = ahpbh_pkg::IOP_W,
  parameter int DATA_W = ahpbh_pkg::DATA_W
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // host request and strobes
  input wire logic I_CS_N,
  input wire logic I_HOST_BUS_REQUEST_N,
  input wire logic I_SUSPEND_BUS_THREE_STATE_N,
  input wire logic I_RD_N,
  input wire logic I_WR_N,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_DATA,
  input wire logic I_EPROM_BOOT,
  // host answers
  output logic O_HOST_BUS_GRANT_N,
  output logic O_HOST_ACCESS_READY,
  output logic O_HOST_ACCESS_READY_OE_N,
  output logic [DATA_W-1:0] O_DATA,
  output logic O_DATA_OE_N,
  // memory interface drive enables
  output logic O_ADDR_SEL_OE_N,
  output logic O_STROBE_OE_N,
  output logic O_BOOT_MEMORY_SELECT_OE_N,
  output logic O_OUTPUT_CLOCK_OE_N,
  // io processor register side
  output logic O_IOP_RD,
  output logic O_IOP_WR,
  output logic [IOP_W-1:0] O_IOP_ADDR,
  output logic [DATA_W-1:0] O_IOP_WDATA,
  input wire logic [DATA_W-1:0] I_IOP_RDATA,
  input wire logic I_IOP_WFIFO_FULL
);

  // ****************************************
  // handoff timing in core cycles
  // ****************************************
  localparam int STB_CYC = CLK_RATIO / 2;
  localparam int BMS_CYC = CLK_RATIO;
  localparam int GRANT_CYC = (3 * CLK_RATIO + 1) / 2;
  localparam int RES_CYC = CLK_RATIO;
  // half a bus clock period in core cycles; 0.5 and 1.5 both round down
  localparam int CLKN_CYC = CLK_RATIO / 2;
  localparam int TAKE_END = RES_CYC + CLKN_CYC;
  localparam int RD_LOW = ahpbh_pkg::RD_LOW_CYC;

  typedef struct packed {
    ahpbh_pkg::ahpbh_bus_t bus;
    ahpbh_pkg::ahpbh_acc_t acc;
    logic [7:0] cnt;
    logic [3:0] acnt;
    logic rd_n;
    logic wr_n;
    logic eprom;
    logic in_iop;
    logic grant_n;
    logic addr_oe_n;
    logic strobe_oe_n;
    logic bms_oe_n;
    logic clk_oe_n;
    logic ready;
    logic data_oe_n;
    logic [DATA_W-1:0] data;
    logic iop_rd;
    logic iop_wr;
    logic [IOP_W-1:0] iop_addr;
    logic [DATA_W-1:0] wdata;
  } ahpbh_state_t;

  ahpbh_state_t s;
  ahpbh_state_t next_s;
  logic addr_in_iop;
  logic rd_start;
  logic wr_start;

  // internal memory sits above the register space and is not reachable
  assign addr_in_iop = (I_ADDR[ADDR_W-1:IOP_W] == '0);
  assign rd_start = s.rd_n && !I_RD_N && !I_CS_N;
  assign wr_start = s.wr_n && !I_WR_N && !I_CS_N;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_s = s;
    next_s.rd_n = I_RD_N;
    next_s.wr_n = I_WR_N;
    next_s.iop_rd = 1'b0;
    next_s.iop_wr = 1'b0;
    case (s.bus)
      ahpbh_pkg::BUS_SYNC:
      begin
        // request already low is simply seen once sync ends
        next_s.cnt = s.cnt + 8'd1;
        if (s.cnt == 8'(ahpbh_pkg::SYNC_CYC - 1))
        begin
          next_s.bus = ahpbh_pkg::BUS_OWN;
          next_s.eprom = I_EPROM_BOOT;
          next_s.addr_oe_n = 1'b0;
          next_s.strobe_oe_n = 1'b0;
          next_s.bms_oe_n = !I_EPROM_BOOT;
          next_s.clk_oe_n = 1'b0;
        end
      end
      ahpbh_pkg::BUS_OWN:
      begin
        next_s.cnt = 8'd0;
        if (!I_SUSPEND_BUS_THREE_STATE_N)
        begin
          next_s.bus = ahpbh_pkg::BUS_SUSP;
          next_s.addr_oe_n = 1'b1;
          next_s.strobe_oe_n = 1'b1;
          next_s.bms_oe_n = 1'b1;
          next_s.clk_oe_n = 1'b1;
        end
        else if (!I_HOST_BUS_REQUEST_N)
        begin
          next_s.bus = ahpbh_pkg::BUS_GIVE;
          next_s.addr_oe_n = 1'b1;
          next_s.clk_oe_n = 1'b1;
        end
      end
      ahpbh_pkg::BUS_GIVE:
      begin
        next_s.cnt = s.cnt + 8'd1;
        if (s.cnt == 8'(STB_CYC - 1))
          next_s.strobe_oe_n = 1'b1;
        if (s.cnt == 8'(BMS_CYC - 1))
          next_s.bms_oe_n = 1'b1;
        if (s.cnt == 8'(GRANT_CYC - 1))
        begin
          next_s.grant_n = 1'b0;
          next_s.bus = ahpbh_pkg::BUS_HOST;
        end
      end
      ahpbh_pkg::BUS_HOST:
      begin
        next_s.cnt = 8'd0;
        if (I_HOST_BUS_REQUEST_N)
        begin
          next_s.grant_n = 1'b1;
          next_s.bus = ahpbh_pkg::BUS_TAKE;
        end
      end
      ahpbh_pkg::BUS_TAKE:
      begin
        next_s.cnt = s.cnt + 8'd1;
        if (s.cnt == 8'(RES_CYC - 1))
        begin
          next_s.addr_oe_n = 1'b0;
          next_s.strobe_oe_n = 1'b0;
          next_s.bms_oe_n = !s.eprom;
        end
        if (s.cnt == 8'(TAKE_END - 1))
        begin
          next_s.clk_oe_n = 1'b0;
          next_s.bus = ahpbh_pkg::BUS_OWN;
        end
      end
      ahpbh_pkg::BUS_SUSP:
      begin
        next_s.cnt = 8'd0;
        if (I_SUSPEND_BUS_THREE_STATE_N)
          next_s.bus = ahpbh_pkg::BUS_TAKE;
      end
      default:
        next_s.bus = ahpbh_pkg::BUS_SYNC;
    endcase

    // ****************************************
    // host register access
    // ****************************************
    case (s.acc)
      ahpbh_pkg::ACC_IDLE:
      begin
        next_s.acnt = 4'd0;
        next_s.iop_addr = I_ADDR[IOP_W-1:0];
        next_s.in_iop = addr_in_iop;
        // strobes count only once the grant is out
        if (s.bus == ahpbh_pkg::BUS_HOST && rd_start)
        begin
          next_s.ready = 1'b0;
          next_s.iop_rd = addr_in_iop;
          next_s.acc = ahpbh_pkg::ACC_RD;
        end
        else if (s.bus == ahpbh_pkg::BUS_HOST && wr_start)
        begin
          next_s.wdata = I_DATA;
          if (I_IOP_WFIFO_FULL)
          begin
            next_s.ready = 1'b0;
            next_s.acc = ahpbh_pkg::ACC_WR;
          end
          else
          begin
            next_s.iop_wr = addr_in_iop;
            next_s.acc = ahpbh_pkg::ACC_DONE;
          end
        end
      end
      ahpbh_pkg::ACC_RD:
      begin
        next_s.acnt = s.acnt + 4'd1;
        if (s.acnt == 4'd0)
        begin
          // data lands before ready rises
          next_s.data = s.in_iop ? I_IOP_RDATA : ahpbh_pkg::DATA_RST;
          next_s.data_oe_n = 1'b0;
        end
        if (s.acnt == 4'(RD_LOW - 1))
        begin
          next_s.ready = 1'b1;
          next_s.acc = ahpbh_pkg::ACC_DONE;
        end
      end
      ahpbh_pkg::ACC_WR:
      begin
        if (!I_IOP_WFIFO_FULL)
        begin
          next_s.ready = 1'b1;
          next_s.iop_wr = s.in_iop;
          next_s.acc = ahpbh_pkg::ACC_DONE;
        end
      end
      ahpbh_pkg::ACC_DONE:
      begin
        if (I_RD_N && I_WR_N)
        begin
          next_s.data_oe_n = 1'b1;
          next_s.acc = ahpbh_pkg::ACC_IDLE;
        end
      end
      default:
        next_s.acc = ahpbh_pkg::ACC_IDLE;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  // reset holds everything, so suspend, requests and remote accesses are ignored
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      s <= '0;
      s.bus <= ahpbh_pkg::BUS_SYNC;
      s.acc <= ahpbh_pkg::ACC_IDLE;
      s.rd_n <= 1'b1;
      s.wr_n <= 1'b1;
      s.grant_n <= 1'b1;
      s.addr_oe_n <= 1'b1;
      s.strobe_oe_n <= 1'b1;
      s.bms_oe_n <= 1'b1;
      s.clk_oe_n <= 1'b1;
      s.ready <= 1'b1;
      s.data_oe_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign O_HOST_BUS_GRANT_N = s.grant_n;
  assign O_HOST_ACCESS_READY = s.ready;
  // active drive only while select and request are both low under grant
  assign O_HOST_ACCESS_READY_OE_N = !(s.bus == ahpbh_pkg::BUS_HOST && !I_CS_N &&
                                      !I_HOST_BUS_REQUEST_N);
  assign O_DATA = s.data;
  assign O_DATA_OE_N = s.data_oe_n;
  assign O_ADDR_SEL_OE_N = s.addr_oe_n;
  assign O_STROBE_OE_N = s.strobe_oe_n;
  assign O_BOOT_MEMORY_SELECT_OE_N = s.bms_oe_n;
  assign O_OUTPUT_CLOCK_OE_N = s.clk_oe_n;
  assign O_IOP_RD = s.iop_rd;
  assign O_IOP_WR = s.iop_wr;
  assign O_IOP_ADDR = s.iop_addr;
  assign O_IOP_WDATA = s.wdata;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  no_early_grant_a: assert property (s.bus == ahpbh_pkg::BUS_SYNC |-> O_HOST_BUS_GRANT_N)
    else $error("grant during bus synchronization");
  iop_only_a: assert property (O_IOP_WR || O_IOP_RD |-> s.in_iop)
    else $error("access outside io register space");
  write_nowait_a: assert property (s.acc == ahpbh_pkg::ACC_IDLE && s.bus == ahpbh_pkg::BUS_HOST
    && wr_start && !rd_start && !I_IOP_WFIFO_FULL |=> O_HOST_ACCESS_READY ##0 O_IOP_WR == s.in_iop)
    else $error("write stalled with room in fifo");
  write_stall_a: assert property (s.acc == ahpbh_pkg::ACC_WR |-> !O_HOST_ACCESS_READY)
    else $error("write wait without ready low");
  read_ready_a: assert property ($fell(O_HOST_ACCESS_READY) && s.acc == ahpbh_pkg::ACC_RD
    |-> !O_HOST_ACCESS_READY ##1 (!O_HOST_ACCESS_READY && !O_DATA_OE_N) ##1 O_HOST_ACCESS_READY)
    else $error("read ready pulse or data order wrong");
  float_before_grant_a: assert property ($fell(O_HOST_BUS_GRANT_N) |-> O_ADDR_SEL_OE_N &&
    O_STROBE_OE_N && O_BOOT_MEMORY_SELECT_OE_N && $past(O_ADDR_SEL_OE_N, 5))
    else $error("interface still driven at grant");
  resume_after_a: assert property ($rose(O_HOST_BUS_GRANT_N) && I_SUSPEND_BUS_THREE_STATE_N
    |-> O_ADDR_SEL_OE_N ##[1:4] !O_ADDR_SEL_OE_N)
    else $error("interface not resumed after grant release");
  // only the resume path staggers the clock; at the end of sync both enables fall together
  clock_offset_a: assert property ($fell(O_OUTPUT_CLOCK_OE_N) && s.bus == ahpbh_pkg::BUS_OWN
    && $past(s.bus == ahpbh_pkg::BUS_TAKE)
    |-> $past(!O_ADDR_SEL_OE_N, CLKN_CYC) && $past(O_ADDR_SEL_OE_N, CLKN_CYC + 1))
    else $error("clock enable offset wrong");
  suspend_float_a: assert property (s.bus == ahpbh_pkg::BUS_SUSP |-> O_ADDR_SEL_OE_N &&
    O_STROBE_OE_N && O_HOST_BUS_GRANT_N)
    else $error("interface driven while suspended");

  handoff_c: cover property ($fell(O_HOST_BUS_GRANT_N) ##[1:50] $rose(O_HOST_BUS_GRANT_N));
  read_c: cover property (O_IOP_RD ##[1:10] O_HOST_ACCESS_READY);
  stall_c: cover property (s.acc == ahpbh_pkg::ACC_WR ##1 O_IOP_WR);
  suspend_c: cover property (s.bus == ahpbh_pkg::BUS_SUSP ##[1:20] s.bus == ahpbh_pkg::BUS_OWN);

endmodule // ahpbh_top

//--- ahpbh_host_model.sv
// host processor model on the asynchronous access port
// assumes the bench calls its tasks from one process and feeds it the ready level
module ahpbh_host_model (
  // clock and device answers
  input wire logic i_clk,
  input wire logic i_grant_n,
  input wire logic i_ready,
  input wire logic [31:0] i_rdata,
  // request and strobes
  output logic o_cs_n,
  output logic o_req_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [ahpbh_pkg::ADDR_W-1:0] o_addr,
  output logic [31:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************
  // host side
  // ************
  // request held from time zero so that it stands across reset
  initial
  begin
    o_cs_n = 1'b0;
    o_req_n = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = '0;
    o_wdata = 32'h0000_0000;
  end

  task automatic req(input logic on);
    @(posedge i_clk);
    #1;
    o_cs_n = !on;
    o_req_n = !on;
  endtask

  task automatic edge_until(input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_ready !== lvl && n < 50);
  endtask

  task automatic rd(input logic [ahpbh_pkg::ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd_n = 1'b0;
    edge_until(1'b0);
    edge_until(1'b1);
    d = i_rdata;
    #1;
    o_rd_n = 1'b1;
  endtask

  task automatic wr(input logic [ahpbh_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr_n = 1'b0;
    repeat (2) @(posedge i_clk);
    edge_until(1'b1);
    #1;
    o_wr_n = 1'b1;
    // released data lines must not keep showing the old word
    o_wdata = ~d;
  endtask
endmodule // ahpbh_host_model

//--- test_async_host_port_bus_handoff.sv
// self-checking bench of the host port and bus handoff
// assumes the host model drives the port and the bench plays the register side
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("ERROR %0t got %0h expected %0h", $time, (a), (b)); \
    end \
  end
module test_async_host_port_bus_handoff;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int R = ahpbh_pkg::CLK_RATIO;
  typedef struct {
    logic wr;
    logic [ahpbh_pkg::ADDR_W-1:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic hit;
  } ahpbh_row_t;
  logic clk, nrst, susp_n, boot, full, cs_n, req_n, rd_n, wr_n, gnt_n, rdy, rdy_oe_n;
  logic dat_oe_n, a_oe_n, s_oe_n, b_oe_n, c_oe_n, iop_rd, iop_wr, cap_wr;
  logic [ahpbh_pkg::ADDR_W-1:0] addr;
  logic [31:0] wdat, dout, iop_rdat, iop_wdat, q, cap_d;
  logic [8:0] iop_addr, cap_a;
  int err_total, checks, cyc, low, np, t_ad, t_st, t_bm, t_cf, t_gn, t_gr, t_ae, t_ck, rel;
  ahpbh_row_t rows [5];
  // pulled-up ready; undriven data shows a flipped word
  wire logic host_rdy = rdy_oe_n ? 1'b1 : rdy;
  wire logic [31:0] host_d = dat_oe_n ? ~dout : dout;

  ahpbh_top uut (
    .I_CLK(clk), .I_NRST(nrst), .I_CS_N(cs_n), .I_HOST_BUS_REQUEST_N(req_n),
    .I_SUSPEND_BUS_THREE_STATE_N(susp_n), .I_RD_N(rd_n), .I_WR_N(wr_n), .I_ADDR(addr),
    .I_DATA(wdat), .I_EPROM_BOOT(boot), .O_HOST_BUS_GRANT_N(gnt_n),
    .O_HOST_ACCESS_READY(rdy), .O_HOST_ACCESS_READY_OE_N(rdy_oe_n), .O_DATA(dout),
    .O_DATA_OE_N(dat_oe_n), .O_ADDR_SEL_OE_N(a_oe_n), .O_STROBE_OE_N(s_oe_n),
    .O_BOOT_MEMORY_SELECT_OE_N(b_oe_n), .O_OUTPUT_CLOCK_OE_N(c_oe_n), .O_IOP_RD(iop_rd),
    .O_IOP_WR(iop_wr), .O_IOP_ADDR(iop_addr), .O_IOP_WDATA(iop_wdat),
    .I_IOP_RDATA(iop_rdat), .I_IOP_WFIFO_FULL(full));
  ahpbh_host_model host (
    .i_clk(clk), .i_grant_n(gnt_n), .i_ready(host_rdy), .i_rdata(host_d), .o_cs_n(cs_n),
    .o_req_n(req_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_wdata(wdat));

  // ************
  // monitors
  // ************
  always @(posedge clk)
  begin
    cyc++;
    if (rdy === 1'b0)
      low++;
    if (iop_rd === 1'b1 || iop_wr === 1'b1)
    begin
      np++;
      cap_a = iop_addr;
      cap_d = iop_wdat;
      cap_wr = iop_wr;
    end
  end
  always @(posedge a_oe_n) t_ad = cyc;
  always @(posedge s_oe_n) t_st = cyc;
  always @(posedge b_oe_n) t_bm = cyc;
  always @(posedge c_oe_n) t_cf = cyc;
  always @(negedge gnt_n) t_gn = cyc;
  always @(posedge gnt_n) t_gr = cyc;
  always @(negedge a_oe_n) t_ae = cyc;
  always @(negedge c_oe_n) t_ck = cyc;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run is about a hundred cycles
  initial
  begin
    #20000;
    err_total++;
    wrap_up();
  end

  initial
  begin
    nrst = 1'b0;
    susp_n = 1'b1;
    boot = 1'b1;
    full = 1'b0;
    iop_rdat = 32'h0000_0000;
    rows[0] = '{1'b1, 18'h0_0010, 32'hA5A5_0001, 32'h0000_0000, 1'b1};
    rows[1] = '{1'b0, 18'h0_01FF, 32'h1234_5678, 32'h1234_5678, 1'b1};
    rows[2] = '{1'b1, 18'h0_0000, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1};
    rows[3] = '{1'b0, 18'h0_0200, 32'hDEAD_BEEF, 32'h0000_0000, 1'b0};
    rows[4] = '{1'b1, 18'h3_FFFF, 32'h5A5A_0F0F, 32'h0000_0000, 1'b0};
    repeat (5) @(posedge clk);
    `CHK({gnt_n, rdy, a_oe_n, dat_oe_n}, 4'hF)
    #1 nrst = 1'b1;
    rel = cyc;
    while (gnt_n !== 1'b0 && cyc < rel + 100)
      @(posedge clk);
    `CHK(t_gn - rel > ahpbh_pkg::SYNC_CYC, 1'b1)
    `CHK(t_st - t_ad, R / 2)
    `CHK(t_bm - t_ad, R)
    `CHK(t_gn - t_ad, (3 * R + 1) / 2)
    `CHK(t_cf, t_ad)
    $display("test handoff done");
    foreach (rows[i])
    begin
      iop_rdat = rows[i].d;
      low = 0;
      np = 0;
      if (rows[i].wr)
        host.wr(rows[i].a, rows[i].d);
      else
        host.rd(rows[i].a, q);
      repeat (2) @(posedge clk);
      `CHK(np, int'(rows[i].hit))
      `CHK(low, rows[i].wr ? 0 : ahpbh_pkg::RD_LOW_CYC)
      if (rows[i].hit)
        `CHK({cap_wr, cap_a}, {rows[i].wr, rows[i].a[8:0]})
      if (rows[i].wr && rows[i].hit)
        `CHK(cap_d, rows[i].d)
      if (!rows[i].wr)
        `CHK(q, rows[i].q)
    end
    $display("test access rows done");
    full = 1'b1;
    np = 0;
    fork
      host.wr(18'h0_0042, 32'h0BAD_F00D);
      begin
        repeat (6) @(posedge clk);
        `CHK({rdy, np}, {1'b0, 0})
        #1 full = 1'b0;
      end
    join
    repeat (2) @(posedge clk);
    `CHK({np, cap_d}, {1, 32'h0BAD_F00D})
    $display("test full stall done");
    host.req(1'b0);
    repeat (12) @(posedge clk);
    `CHK(t_ae - t_gr, R)
    `CHK(t_ck - t_gr, R + R / 2)
    `CHK({s_oe_n, b_oe_n}, 2'b00)
    $display("test release done");
    #1 susp_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK({a_oe_n, s_oe_n, b_oe_n, c_oe_n}, 4'hF)
    susp_n = 1'b1;
    repeat (12) @(posedge clk);
    #1 `CHK({a_oe_n, s_oe_n, b_oe_n, c_oe_n}, 4'h0)
    $display("test suspend done");
    wrap_up();
  end
endmodule // test_async_host_port_bus_handoff
